// file: design/rpac_pkg.sv
// rpac_pkg: constants for the per-port alias and setup register group
// assumes a byte-wide register port from the local i2c target engine
package rpac_pkg;
   localparam int RPAC_PORTS = 2;
   localparam logic [7:0] RPAC_OFS_PORT_SEL = 8'h4C;
   localparam logic [7:0] RPAC_OFS_ALIAS5 = 8'h6A;
   localparam logic [7:0] RPAC_OFS_ALIAS6 = 8'h6B;
   localparam logic [7:0] RPAC_OFS_ALIAS7 = 8'h6C;
   localparam logic [7:0] RPAC_OFS_SETUP = 8'h6D;
   localparam int RPAC_NSLOT = 3;
   localparam logic [7:0] RPAC_ALIAS_RST = 8'h00;
   localparam logic [6:0] RPAC_ALIAS_OFF = 7'h00;
   localparam logic [7:0] RPAC_PSEL_RST = 8'h00;
   // setup register bit positions
   localparam int RPAC_B_WFS1 = 7;
   localparam int RPAC_B_WFS = 6;
   localparam int RPAC_B_CKS = 5;
   localparam int RPAC_B_ECC = 4;
   localparam int RPAC_B_LEN = 3;
   localparam int RPAC_B_COAX = 2;
   localparam int RPAC_B_FMT_HI = 1;
   // upper bits 7:3 reset value; low bits come from the strap
   // frame start wait and all three forward bits reset set
   localparam logic [4:0] RPAC_SETUP_HI_RST = 5'h0F;
   localparam logic [15:0] RPAC_FC_ONE = 16'h0001;
   typedef enum logic [1:0] {
      RPAC_FMT_CSI = 2'h0,
      RPAC_FMT_RAW12_50 = 2'h1,
      RPAC_FMT_RAW12_75 = 2'h2,
      RPAC_FMT_RAW10_100 = 2'h3
   } rpac_fmt_t;
endpackage : rpac_pkg

// file: design/rpac_top.sv
// rpac_top: per-receive-port alias decoders and receive port setup
// assumes a synchronous byte register port and packet-level csi/raw flags
`timescale 1ns/10ps
module rpac_top
   import rpac_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic power_down_pin_n,
   input wire logic [2:0] mode_strap,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic [6:0] i2c_addr,
   input wire logic i2c_addr_vld,
   input wire logic i2c_is_write,
   input wire logic i2c_port,
   input wire logic [6:0] remote_id_slot5,
   input wire logic [6:0] remote_id_slot6,
   input wire logic [6:0] remote_id_slot7,
   input wire logic remote_ack,
   output logic fwd_vld,
   output logic [6:0] fwd_addr,
   output logic local_ack,
   input wire logic [1:0] pkt_port,
   input wire logic pkt_vld,
   input wire logic pkt_fs,
   input wire logic [15:0] pkt_frame_cnt,
   input wire logic pkt_cks_err,
   input wire logic pkt_ecc_err,
   input wire logic pkt_len_err,
   input wire logic pkt_first_line_trunc,
   output logic pkt_pass,
   output logic [1:0] port_format,
   output logic port_coax
);
   logic [7:0] alias_ff [RPAC_PORTS][RPAC_NSLOT];
   logic [7:0] setup_ff [RPAC_PORTS];
   logic [7:0] psel_ff;
   logic [RPAC_PORTS-1:0] seen_fs_ff;
   logic [RPAC_PORTS-1:0] seen_fs1_ff;
   logic strap_done_ff;
   logic pin_q_ff;
   logic psel_idx;
   logic [1:0] slot_wr;
   logic slot_hit;
   logic pp;
   logic fwd_vld_ff;
   logic [6:0] fwd_addr_ff;
   logic local_ack_ff;
   logic [7:0] nxt_rdata;

   function automatic logic is_slot(input logic [7:0] a);
      return (a >= RPAC_OFS_ALIAS5) && (a <= RPAC_OFS_ALIAS7);
   endfunction : is_slot

   // only meaningful while is_slot holds
   function automatic logic [1:0] slot_of(input logic [7:0] a);
      logic [7:0] d;
      d = a - RPAC_OFS_ALIAS5;
      return d[1:0];
   endfunction : slot_of

   // only port bit 0 is decoded; two receive ports
   assign psel_idx = psel_ff[0];
   assign slot_hit = is_slot(reg_addr);
   assign slot_wr = slot_of(reg_addr);

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         psel_ff <= RPAC_PSEL_RST;
      end else if (reg_wr && reg_addr == RPAC_OFS_PORT_SEL) begin
         psel_ff <= reg_wdata;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         for (int p = 0; p < RPAC_PORTS; p++) begin
            for (int s = 0; s < RPAC_NSLOT; s++) begin
               alias_ff[p][s] <= RPAC_ALIAS_RST;
            end
         end
      end else if (reg_wr && slot_hit) begin
         alias_ff[psel_idx][slot_wr] <= reg_wdata;
      end
   end

   // strap sampled on the first clock that sees the pin high
   // limitation: only the first pin release after reset restraps
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         pin_q_ff <= 1'b0;
         strap_done_ff <= 1'b0;
      end else begin
         pin_q_ff <= power_down_pin_n;
         if (power_down_pin_n && !pin_q_ff) begin
            strap_done_ff <= 1'b1;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         for (int p = 0; p < RPAC_PORTS; p++) begin
            setup_ff[p] <= {RPAC_SETUP_HI_RST, 3'h0};
         end
      end else begin
         for (int p = 0; p < RPAC_PORTS; p++) begin
            if (power_down_pin_n && !pin_q_ff && !strap_done_ff) begin
               setup_ff[p][RPAC_B_COAX:0] <= mode_strap;
            end
         end
         // software write after strap wins the same cycle
         if (reg_wr && reg_addr == RPAC_OFS_SETUP) begin
            setup_ff[psel_idx] <= reg_wdata;
         end
      end
   end

   always_comb begin
      nxt_rdata = 8'h00;
      if (reg_addr == RPAC_OFS_PORT_SEL) begin
         nxt_rdata = psel_ff;
      end else if (reg_addr == RPAC_OFS_SETUP) begin
         nxt_rdata = setup_ff[psel_idx];
      end else if (slot_hit) begin
         nxt_rdata = alias_ff[psel_idx][slot_wr];
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata <= nxt_rdata;
      end
   end

   // alias decode: first matching slot wins
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         fwd_vld_ff <= 1'b0;
         fwd_addr_ff <= 7'h00;
         local_ack_ff <= 1'b0;
      end else begin
         fwd_vld_ff <= 1'b0;
         // cleared between hits so a stale remap never lingers
         fwd_addr_ff <= 7'h00;
         local_ack_ff <= 1'b0;
         if (i2c_addr_vld) begin
            for (int s = RPAC_NSLOT - 1; s >= 0; s--) begin
               if (alias_ff[i2c_port][s][7:1] != RPAC_ALIAS_OFF &&
                   alias_ff[i2c_port][s][7:1] == i2c_addr) begin
                  fwd_vld_ff <= 1'b1;
                  fwd_addr_ff <= (s == 0) ? remote_id_slot5 :
                                 (s == 1) ? remote_id_slot6 : remote_id_slot7;
                  local_ack_ff <= (i2c_is_write && alias_ff[i2c_port][s][0]) ||
                                  remote_ack;
               end
            end
         end
      end
   end
   assign fwd_vld = fwd_vld_ff;
   assign fwd_addr = fwd_addr_ff;
   assign local_ack = local_ack_ff;

   // frame-start gating per port
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         seen_fs_ff <= '0;
         seen_fs1_ff <= '0;
      end else if (pkt_vld && pkt_fs) begin
         seen_fs_ff[pp] <= 1'b1;
         if (pkt_frame_cnt == RPAC_FC_ONE) begin
            seen_fs1_ff[pp] <= 1'b1;
         end
      end
   end

   assign pp = pkt_port[0];

   always_comb begin
      logic [7:0] c;
      logic raw;
      c = setup_ff[pp];
      raw = c[RPAC_B_FMT_HI -: 2] != RPAC_FMT_CSI;
      pkt_pass = pkt_vld;
      if (c[RPAC_B_WFS1] && !seen_fs1_ff[pp] &&
          !(pkt_fs && pkt_frame_cnt == RPAC_FC_ONE)) begin
         pkt_pass = 1'b0;
      end
      if (c[RPAC_B_WFS] && !seen_fs_ff[pp] && !pkt_fs) begin
         pkt_pass = 1'b0;
      end
      if (pkt_cks_err && !c[RPAC_B_CKS]) begin
         pkt_pass = 1'b0;
      end
      if (pkt_ecc_err && !c[RPAC_B_ECC]) begin
         pkt_pass = 1'b0;
      end
      if (!raw && pkt_len_err && !c[RPAC_B_LEN]) begin
         pkt_pass = 1'b0;
      end
      if (raw && pkt_first_line_trunc && c[RPAC_B_LEN]) begin
         pkt_pass = 1'b0;
      end
   end

   assign port_format = setup_ff[psel_idx][RPAC_B_FMT_HI -: 2];
   assign port_coax = setup_ff[psel_idx][RPAC_B_COAX];

   AST_ZERO_NO_FWD: assert property (@(posedge mclk) disable iff (!rst_n)
      fwd_vld |-> $past(i2c_addr) != RPAC_ALIAS_OFF)
      else $error("forward on a zero alias");
   AST_WR_PSEL: assert property (@(posedge mclk) disable iff (!rst_n)
      reg_wr && reg_addr == RPAC_OFS_PORT_SEL |=> psel_ff == $past(reg_wdata))
      else $error("port select not written");
   AST_CKS_DROP: assert property (@(posedge mclk) disable iff (!rst_n)
      pkt_cks_err && !setup_ff[pp][RPAC_B_CKS] |-> !pkt_pass)
      else $error("checksum error packet passed");
   AST_ECC_DROP: assert property (@(posedge mclk) disable iff (!rst_n)
      pkt_ecc_err && !setup_ff[pp][RPAC_B_ECC] |-> !pkt_pass)
      else $error("ecc error packet passed");
   AST_WAIT_FS: assert property (@(posedge mclk) disable iff (!rst_n)
      setup_ff[pp][RPAC_B_WFS] && !seen_fs_ff[pp] && !pkt_fs |-> !pkt_pass)
      else $error("packet before frame start");
   AST_WAIT_FS1: assert property (@(posedge mclk) disable iff (!rst_n)
      setup_ff[pp][RPAC_B_WFS1] && !seen_fs1_ff[pp] && !pkt_fs |-> !pkt_pass)
      else $error("packet before frame count one");
   AST_AUTO_ACK: assert property (@(posedge mclk) disable iff (!rst_n)
      fwd_vld && !local_ack |-> !$past(remote_ack))
      else $error("ack missing");
   AST_SETUP_RST: assert property (@(posedge mclk)
      $rose(rst_n) |-> setup_ff[0][7:3] == RPAC_SETUP_HI_RST)
      else $error("setup reset value wrong");

   // alias path checks
   AST_SLOT5_MAP: assert property (@(posedge mclk) disable iff (!rst_n)
      i2c_addr_vld && i2c_addr != RPAC_ALIAS_OFF && alias_ff[i2c_port][0][7:1] == i2c_addr
      |=> fwd_vld && fwd_addr == $past(remote_id_slot5))
      else $error("slot5 remap wrong");
   AST_FWD_PULSE: assert property (@(posedge mclk) disable iff (!rst_n)
      fwd_vld |-> $past(i2c_addr_vld))
      else $error("forward without lookup");
   AST_ZERO_ADDR: assert property (@(posedge mclk) disable iff (!rst_n)
      i2c_addr_vld && i2c_addr == RPAC_ALIAS_OFF |=> !fwd_vld)
      else $error("zero address forwarded");
   AST_AUTO_WR_ACK: assert property (@(posedge mclk) disable iff (!rst_n)
      i2c_addr_vld && i2c_is_write && i2c_addr != RPAC_ALIAS_OFF &&
      alias_ff[i2c_port][0] == {i2c_addr, 1'b1} |=> local_ack)
      else $error("auto ack missing on write");
   AST_ACK_WITH_FWD: assert property (@(posedge mclk) disable iff (!rst_n)
      local_ack |-> fwd_vld)
      else $error("ack without forward");

   // packet filter checks
   AST_LEN_DROP: assert property (@(posedge mclk) disable iff (!rst_n)
      pkt_len_err && setup_ff[pp][RPAC_B_FMT_HI -: 2] == RPAC_FMT_CSI &&
      !setup_ff[pp][RPAC_B_LEN] |-> !pkt_pass)
      else $error("length error packet passed");
   AST_TRUNC_DROP: assert property (@(posedge mclk) disable iff (!rst_n)
      pkt_first_line_trunc && setup_ff[pp][RPAC_B_FMT_HI -: 2] != RPAC_FMT_CSI &&
      setup_ff[pp][RPAC_B_LEN] |-> !pkt_pass)
      else $error("truncated first line passed");
   AST_FS_SEEN: assert property (@(posedge mclk) disable iff (!rst_n)
      pkt_vld && pkt_fs && !pkt_port[0] |=> seen_fs_ff[0])
      else $error("frame start not noted");
   AST_FS1_SEEN: assert property (@(posedge mclk) disable iff (!rst_n)
      pkt_vld && pkt_fs && pkt_port[0] && pkt_frame_cnt == RPAC_FC_ONE |=> seen_fs1_ff[1])
      else $error("frame count one not noted");
   AST_PASS_NEEDS_VLD: assert property (@(posedge mclk) disable iff (!rst_n)
      pkt_pass |-> pkt_vld)
      else $error("pass without packet");

   // register checks
   AST_STRAP: assert property (@(posedge mclk) disable iff (!rst_n)
      power_down_pin_n && !pin_q_ff && !strap_done_ff &&
      !(reg_wr && reg_addr == RPAC_OFS_SETUP) |=> setup_ff[0][RPAC_B_COAX:0] == $past(mode_strap))
      else $error("strap not latched");
   AST_RD_SETUP: assert property (@(posedge mclk) disable iff (!rst_n)
      reg_rd && reg_addr == RPAC_OFS_SETUP |=> reg_rdata == $past(setup_ff[psel_idx]))
      else $error("setup read wrong port");
   AST_ALIAS_STEER: assert property (@(posedge mclk) disable iff (!rst_n)
      reg_wr && reg_addr == RPAC_OFS_ALIAS5 |=> alias_ff[psel_idx][0] == $past(reg_wdata))
      else $error("alias write not steered");
   AST_RD_UNMAPPED: assert property (@(posedge mclk) disable iff (!rst_n)
      reg_rd && reg_addr > RPAC_OFS_SETUP |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   AST_PSEL_KEEP: assert property (@(posedge mclk) disable iff (!rst_n)
      !(reg_wr && reg_addr == RPAC_OFS_PORT_SEL) |=> $stable(psel_ff))
      else $error("port select changed unasked");

   COV_FWD: cover property (@(posedge mclk) fwd_vld);
   COV_DROP: cover property (@(posedge mclk) pkt_vld && !pkt_pass);
   COV_AUTOACK: cover property (@(posedge mclk) local_ack && !$past(remote_ack));
   COV_RAW_TRUNC: cover property (@(posedge mclk) pkt_vld && pkt_first_line_trunc && !pkt_pass);
   COV_FS1_OPEN: cover property (@(posedge mclk) pkt_vld && pkt_fs && pkt_frame_cnt == RPAC_FC_ONE);
endmodule : rpac_top

// file: sim/rpac_remote_model.sv
// rpac_remote_model: far serializer ack and paired remote target ids
// assumes the ack is sampled at the same edge as the lookup request
`timescale 1ns/10ps
module rpac_remote_model (
   input wire logic nack_req,
   output logic remote_ack,
   output logic [6:0] id5,
   output logic [6:0] id6,
   output logic [6:0] id7
);
   // refuses on command, so auto-ack is seen to override it
   assign remote_ack = !nack_req;
   assign id5 = 7'h15;
   assign id6 = 7'h26;
   assign id7 = 7'h37;
endmodule : rpac_remote_model

// file: sim/testbench.sv
// testbench: registers, alias lookups and packet filter of rpac_top
// assumes rpac_remote_model on the far side of the alias path
`timescale 1ns/10ps
module testbench;
   import rpac_pkg::*;
   logic mclk, rst_n, pwr_n, wr, rd, av, aw, ap, nack, pv, pfs, pc, pe, pl, pt;
   logic pass, coax, fv, la, ra, sr, si;
   logic [2:0] strap;
   logic [7:0] addr, wd, rdat;
   logic [6:0] ia, fa, id5, id6, id7;
   logic [1:0] pp, fmt;
   logic [15:0] fc;
   logic [31:0] lf;
   logic [7:0] rq[$];
   logic [8:0] iq[$];
   logic pq[$];
   logic [12:0] tab[8];
   int fail_count, compares;
   rpac_top rpac_top_inst (.mclk(mclk), .rst_n(rst_n), .power_down_pin_n(pwr_n),
      .mode_strap(strap), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr), .reg_wdata(wd),
      .reg_rdata(rdat), .i2c_addr(ia), .i2c_addr_vld(av), .i2c_is_write(aw), .i2c_port(ap),
      .remote_id_slot5(id5), .remote_id_slot6(id6), .remote_id_slot7(id7),
      .remote_ack(ra), .fwd_vld(fv), .fwd_addr(fa), .local_ack(la), .pkt_port(pp),
      .pkt_vld(pv), .pkt_fs(pfs), .pkt_frame_cnt(fc), .pkt_cks_err(pc), .pkt_ecc_err(pe),
      .pkt_len_err(pl), .pkt_first_line_trunc(pt), .pkt_pass(pass), .port_format(fmt),
      .port_coax(coax));
   rpac_remote_model rpac_remote_model_inst (.nack_req(nack), .remote_ack(ra), .id5(id5),
      .id6(id6), .id7(id7));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic cmp_byte(input string n, input logic [7:0] e, input logic [7:0] g);
      compares++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask : cmp_byte
   task automatic cmp_fwd(input logic [8:0] e, input logic [8:0] g);
      compares++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] fwd expected %h seen %h", e, g);
      end
   endtask : cmp_fwd
   task automatic end_sim;
      if (fail_count == 0 && compares > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : end_sim
   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk);
      wr = 1'b1;
      addr = a;
      wd = d;
      @(negedge mclk);
      wr = 1'b0;
   endtask : wreg
   task automatic rreg(input logic [7:0] a, input logic [7:0] e);
      @(negedge mclk);
      rd = 1'b1;
      addr = a;
      rq.push_back(e);
      @(negedge mclk);
      rd = 1'b0;
   endtask : rreg
   task automatic look(input logic [6:0] a, input logic w, input logic p, input logic [8:0] e);
      @(negedge mclk);
      av = 1'b1;
      ia = a;
      aw = w;
      ap = p;
      iq.push_back(e);
      @(negedge mclk);
      av = 1'b0;
   endtask : look
   task automatic pkt(input logic p, input logic fs, input logic [15:0] c,
      input logic [3:0] err, input logic e);
      @(negedge mclk);
      pv = 1'b1;
      pp = {1'b0, p};
      pfs = fs;
      fc = c;
      {pc, pe, pl, pt} = err;
      if (!fs) pq.push_back(e);
      @(negedge mclk);
      pv = 1'b0;
   endtask : pkt
   // outputs are registered on the request edge itself, so look just after it
   always @(posedge mclk) begin
      sr = rd;
      si = av;
      #1;
      if (sr) cmp_byte("reg_rdata", rq.pop_front(), rdat);
      if (si) cmp_fwd(iq.pop_front(), {fv, fa, la});
      else if (rst_n) cmp_fwd(9'h000, {fv, fa, la});
   end
   // packet verdict is combinational, so look 2 ns after the falling edge that drives it
   always @(negedge mclk) begin
      #2;
      if (pv && !pfs) cmp_byte("pkt_pass", {7'h00, pq.pop_front()}, {7'h00, pass});
   end
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   initial begin
      #20000;
      fail_count++;
      end_sim();
   end
   initial begin
      {rst_n, pwr_n, wr, rd, av, aw, ap, nack, pv, pfs, pc, pe, pl, pt} = '0;
      {addr, wd, ia, pp, fc} = '0;
      tab = '{{8'h3C, 4'h8, 1'b1}, {8'h1C, 4'h8, 1'b0}, {8'h1C, 4'h4, 1'b1},
         {8'h0C, 4'h4, 1'b0}, {8'h0C, 4'h2, 1'b1}, {8'h04, 4'h2, 1'b0},
         {8'h05, 4'h1, 1'b1}, {8'h0D, 4'h1, 1'b0}};
      lf = 32'hC7D4;
      strap = lf[2:0];
      repeat (3) @(negedge mclk);
      rst_n = 1'b1;
      @(negedge mclk);
      pwr_n = 1'b1;
      rreg(RPAC_OFS_SETUP, {5'h0F, strap});
      rreg(RPAC_OFS_ALIAS5, 8'h00);
      pkt(1'b0, 1'b0, 16'h0001, 4'h0, 1'b0);
      pkt(1'b0, 1'b1, 16'h0002, 4'h0, 1'b0);
      pkt(1'b0, 1'b0, 16'h0002, 4'h0, 1'b1);
      wreg(RPAC_OFS_PORT_SEL, 8'h01);
      wreg(RPAC_OFS_ALIAS5, 8'hA3);
      wreg(RPAC_OFS_ALIAS6, 8'hA4);
      rreg(RPAC_OFS_ALIAS5, 8'hA3);
      wreg(RPAC_OFS_PORT_SEL, 8'h00);
      rreg(RPAC_OFS_ALIAS5, 8'h00);
      nack = 1'b1;
      look(7'h51, 1'b1, 1'b1, {1'b1, 7'h15, 1'b1});
      look(7'h52, 1'b1, 1'b1, {1'b1, 7'h26, 1'b0});
      look(7'h51, 1'b1, 1'b0, 9'h000);
      look(7'h00, 1'b1, 1'b1, 9'h000);
      nack = 1'b0;
      look(7'h52, 1'b0, 1'b1, {1'b1, 7'h26, 1'b1});
      lf = lfsr(lf);
      wreg(RPAC_OFS_ALIAS7, lf[7:0]);
      rreg(RPAC_OFS_ALIAS7, lf[7:0]);
      rreg(8'h6E, 8'h00);
      for (int f = 0; f < 4; f++) begin
         wreg(RPAC_OFS_SETUP, {5'h07, f[0], 2'(3 - f)});
         cmp_byte("setup", {5'h00, f[0], 2'(3 - f)}, {5'h00, coax, fmt});
      end
      foreach (tab[i]) begin
         wreg(RPAC_OFS_SETUP, tab[i][12:5]);
         pkt(1'b0, 1'b0, 16'h0002, tab[i][4:1], tab[i][0]);
      end
      wreg(RPAC_OFS_PORT_SEL, 8'h01);
      wreg(RPAC_OFS_SETUP, 8'hB8);
      pkt(1'b1, 1'b1, 16'h0002, 4'h0, 1'b0);
      pkt(1'b1, 1'b0, 16'h0002, 4'h0, 1'b0);
      pkt(1'b1, 1'b1, 16'h0001, 4'h0, 1'b0);
      pkt(1'b1, 1'b0, 16'h0002, 4'h0, 1'b1);
      end_sim();
   end
endmodule : testbench
